/* File: hw/ubc_pkg.sv */
// Function
// - wake-up enable set and power-down: falling RX edge wakes the device.
// - wake-up enable clear: no RX edge of any kind wakes the device.
// - address bit is word bit 7 in 8-bit format, ninth bit in 9-bit.
// - address detect plus receive interrupt: request for every word with address bit.
// - address detect: word with address bit 0 gives no request and is discarded.
// - speed select 1 picks high speed baud mode, 0 low speed.
// - receiver enable 0 disables receiver, aborts reception, resets buffer, frees RX.
// - UART owns RX only while receiver enable and master enable are both 1.
// - clearing receiver enable mid-word aborts at once and resets the receiver.
// - transmitter enable 0 disables, aborts sending, resets buffer, frees TX.
// - UART owns TX only while transmitter enable and master enable are both 1.
// - clearing transmitter enable mid-character stops at once and resets it.
// - bit rate comes from a free-running 8-bit timer set by divisor and speed.
// - baud divisor is unsigned 8-bit, every value 0 through 255 accepted.
// - bit rate is clock/(64(N+1)) low speed, clock/(16(N+1)) high speed.
// - transmitter and receiver independent but share format and baud rate.
// - master enable 0 disables the UART; RX and TX act as plain I/O.
// - 8/9-bit select 1 gives 9-bit words; ninth received bit held in a field.
package ubc_pkg;

  // ***************************************************************
  // clock
  // ***************************************************************
  localparam int unsigned SYSTEM_CLOCK_FREQ_HZ = 10_000_000;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] OFS_CONTROL_SECOND = 8'h00;  // uart_control_second
  localparam logic [7:0] OFS_BAUD_DIVISOR   = 8'h04;  // baud_divisor
  localparam logic [7:0] OFS_CONTROL_FIRST  = 8'h08;  // master enable, 8/9-bit select
  localparam logic [7:0] OFS_STATUS         = 8'h0c;  // status; any write clears the wake record

  // ***************************************************************
  // uart_control_second field positions
  // ***************************************************************
  localparam int BIT_TX_EMPTY_IE  = 7;
  localparam int BIT_TX_IDLE_IE   = 6;
  localparam int BIT_RX_IE        = 5;
  localparam int BIT_WAKE_EN      = 4;
  localparam int BIT_ADDR_DET_EN  = 3;
  localparam int BIT_HIGH_SPEED   = 2;
  localparam int BIT_RX_EN        = 1;
  localparam int BIT_TX_EN        = 0;

  // control_first and status field positions
  localparam int BIT_MASTER_EN    = 0;
  localparam int BIT_NINE_BIT_SEL = 1;
  localparam int BIT_ST_NINTH     = 0;
  localparam int BIT_ST_RX_OWN    = 1;
  localparam int BIT_ST_TX_OWN    = 2;
  localparam int BIT_ST_WOKE      = 3;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] RST_CONTROL_SECOND = 8'h00;
  localparam logic [7:0] RST_BAUD_DIVISOR   = 8'h00;
  localparam logic [1:0] RST_CONTROL_FIRST  = 2'h0;

  // ***************************************************************
  // baud prescale counts (clock cycles per timer step)
  // ***************************************************************
  localparam logic [5:0] PRESCALE_LOW_LAST  = 6'h3f;  // 64 cycles
  localparam logic [5:0] PRESCALE_HIGH_LAST = 6'h0f;  // 16 cycles
  localparam int unsigned PRESCALE_LOW      = 64;
  localparam int unsigned PRESCALE_HIGH     = 16;

endpackage : ubc_pkg

/* File: hw/ubc_baud_gen.sv */
`timescale 1ns/100ps
// ***************************************************************
// free-running baud timer
// ***************************************************************
module ubc_baud_gen (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       enable_in,
  input  wire logic       high_speed_in,
  input  wire logic [7:0] divisor_in,
  output logic            tick_out
);

  logic [5:0] prescale;
  logic [7:0] timer;
  logic       step;

  // one step of the 8-bit timer every 64 or 16 clocks
  assign step = (prescale == (high_speed_in ? ubc_pkg::PRESCALE_HIGH_LAST
                                            : ubc_pkg::PRESCALE_LOW_LAST));

  // prescaler, cleared while the uart is off
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !enable_in || step) begin
      prescale <= 6'h00;
    end else begin
      prescale <= prescale + 6'h01;
    end
  end

  // timer reloads from the divisor at the end of each period
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !enable_in) begin
      timer    <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= step && (timer == 8'h00);
      if (step) begin
        timer <= (timer == 8'h00) ? divisor_in : timer - 8'h01;
      end
    end
  end

  // helper: cycles since last tick with settings held steady
  logic [15:0] gap;
  logic        steady;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !enable_in) begin
      gap    <= 16'h0000;
      steady <= 1'b0;
    end else if (tick_out) begin
      gap    <= 16'h0001;
      steady <= !($changed(divisor_in) || $changed(high_speed_in));  // change on the reload edge
    end else begin
      gap <= gap + 16'h0001;
      if ($changed(divisor_in) || $changed(high_speed_in)) begin
        steady <= 1'b0;
      end
    end
  end

  baud_period_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (tick_out && steady && $stable(divisor_in) && $stable(high_speed_in)) |->
      (32'(gap) == (32'(divisor_in) + 32'd1) *
        (high_speed_in ? ubc_pkg::PRESCALE_HIGH : ubc_pkg::PRESCALE_LOW)))
    else $error("baud tick period wrong");

endmodule : ubc_baud_gen

/* File: hw/ubc_control.sv */
`timescale 1ns/100ps
module ubc_control (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pin and system side
  input  wire logic        rx_pin_in,
  input  wire logic        power_down_in,
  output logic             wake_out,
  // receiver core side
  input  wire logic        rx_word_valid_in,
  input  wire logic [7:0]  rx_word_in,
  input  wire logic        rx_bit_eight_in,
  input  wire logic        rx_busy_in,
  input  wire logic        tx_busy_in,
  output logic             rx_deliver_out,
  output logic [7:0]       rx_data_out,
  output logic             uart_irq_out,
  // enables and resets toward the shifters
  output logic             rx_pin_own_out,
  output logic             tx_pin_own_out,
  output logic             rx_reset_out,
  output logic             tx_reset_out,
  output logic             rx_abort_out,
  output logic             tx_abort_out,
  output logic             nine_bit_select_out,
  output logic             baud_tick_out
);

  // ***************************************************************
  // register storage
  // ***************************************************************
  logic [7:0] uart_control_second;
  logic [7:0] baud_divisor;
  logic       uart_master_enable;
  logic       nine_bit_select;
  logic       received_ninth_bit;
  logic       woke;

  logic       receiver_enable;
  logic       transmitter_enable;
  logic       address_detect_enable;
  logic       baud_high_speed_select;
  logic       rx_int_enable;
  logic       wake_enable;

  // control bits of the second control word, decoded by name
  assign receiver_enable        = uart_control_second[ubc_pkg::BIT_RX_EN];
  assign transmitter_enable     = uart_control_second[ubc_pkg::BIT_TX_EN];
  assign address_detect_enable  = uart_control_second[ubc_pkg::BIT_ADDR_DET_EN];
  assign baud_high_speed_select = uart_control_second[ubc_pkg::BIT_HIGH_SPEED];
  assign rx_int_enable          = uart_control_second[ubc_pkg::BIT_RX_IE];
  assign wake_enable            = uart_control_second[ubc_pkg::BIT_WAKE_EN];

  // ***************************************************************
  // apb decode
  // ***************************************************************
  logic wr_en;
  logic setup;
  logic mapped;

  // only the four register words answer without error
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ubc_pkg::OFS_CONTROL_SECOND) || (a == ubc_pkg::OFS_BAUD_DIVISOR) ||
                (a == ubc_pkg::OFS_CONTROL_FIRST) || (a == ubc_pkg::OFS_STATUS);
  endfunction : is_mapped

  assign setup  = psel && !penable && !pready;
  assign mapped = is_mapped(paddr);
  assign wr_en  = psel && penable && pready && pwrite && mapped;

  // one wait-free access: ready raised for the access phase
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
    end
  end

  // read data captured during setup, unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      unique case (paddr)
        ubc_pkg::OFS_CONTROL_SECOND: prdata <= {24'h000000, uart_control_second};
        ubc_pkg::OFS_BAUD_DIVISOR:   prdata <= {24'h000000, baud_divisor};
        ubc_pkg::OFS_CONTROL_FIRST:  prdata <= {30'h00000000, nine_bit_select,
                                                uart_master_enable};
        ubc_pkg::OFS_STATUS:         prdata <= {28'h0000000, woke, tx_pin_own_out,
                                                rx_pin_own_out, received_ninth_bit};
        default:                     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ***************************************************************
  // control registers
  // ***************************************************************
  // master enable off clears both direction enables, other bits kept
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      uart_control_second <= ubc_pkg::RST_CONTROL_SECOND;
    end else if (wr_en && paddr == ubc_pkg::OFS_CONTROL_SECOND) begin
      uart_control_second <= pwdata[7:0];
    end else if (!uart_master_enable) begin
      uart_control_second[ubc_pkg::BIT_RX_EN] <= 1'b0;
      uart_control_second[ubc_pkg::BIT_TX_EN] <= 1'b0;
    end
  end

  // divisor takes every 8-bit value; timer picks it up at reload
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      baud_divisor <= ubc_pkg::RST_BAUD_DIVISOR;
    end else if (wr_en && paddr == ubc_pkg::OFS_BAUD_DIVISOR) begin
      baud_divisor <= pwdata[7:0];
    end
  end

  // master enable and word length select
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      {nine_bit_select, uart_master_enable} <= ubc_pkg::RST_CONTROL_FIRST;
    end else if (wr_en && paddr == ubc_pkg::OFS_CONTROL_FIRST) begin
      uart_master_enable <= pwdata[ubc_pkg::BIT_MASTER_EN];
      nine_bit_select    <= pwdata[ubc_pkg::BIT_NINE_BIT_SEL];
    end
  end

  // ***************************************************************
  // pin ownership and direction resets
  // ***************************************************************
  // ownership and resets follow the enables one cycle later; a shifter
  // stays in reset for as long as its direction is off
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_pin_own_out      <= 1'b0;
      tx_pin_own_out      <= 1'b0;
      rx_reset_out        <= 1'b1;
      tx_reset_out        <= 1'b1;
      rx_abort_out        <= 1'b0;
      tx_abort_out        <= 1'b0;
      nine_bit_select_out <= 1'b0;
    end else begin
      rx_pin_own_out      <= receiver_enable && uart_master_enable;
      tx_pin_own_out      <= transmitter_enable && uart_master_enable;
      rx_reset_out        <= !(receiver_enable && uart_master_enable);
      tx_reset_out        <= !(transmitter_enable && uart_master_enable);
      rx_abort_out        <= rx_busy_in && !(receiver_enable && uart_master_enable);
      tx_abort_out        <= tx_busy_in && !(transmitter_enable && uart_master_enable);
      nine_bit_select_out <= nine_bit_select;
    end
  end

  // ownership never outlives its enables; abort follows a cleared enable
  rx_pin_own_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    rx_pin_own_out |-> $past(receiver_enable) && $past(uart_master_enable))
    else $error("rx pin owned while disabled");

  tx_pin_own_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tx_pin_own_out |-> $past(transmitter_enable) && $past(uart_master_enable))
    else $error("tx pin owned while disabled");

  rx_abort_now_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ($fell(receiver_enable) && rx_busy_in) |=> rx_abort_out && rx_reset_out)
    else $error("reception not aborted at once");

  tx_abort_now_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ($fell(transmitter_enable) && tx_busy_in) |=> tx_abort_out && tx_reset_out)
    else $error("transmission not stopped at once");

  // ***************************************************************
  // shared baud generator
  // ***************************************************************
  // one generator serves both directions, so they share one bit rate
  ubc_baud_gen u_baud (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .enable_in     (uart_master_enable),
    .high_speed_in (baud_high_speed_select),
    .divisor_in    (baud_divisor),
    .tick_out      (baud_tick_out)
  );

  // ***************************************************************
  // rx wake-up from power-down
  // ***************************************************************
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  logic rx_fall;

  // two-stage synchroniser, then edge history
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= rx_pin_in;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // falling edge: high one cycle, low the next
  assign rx_fall = rx_prev && !rx_sync;

  // only a falling edge, and only with wake enabled
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= wake_enable && power_down_in && rx_fall;
    end
  end

  // sticky record of a wake, cleared by a status write; set wins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      woke <= 1'b0;
    end else if (wake_out) begin
      woke <= 1'b1;
    end else if (wr_en && paddr == ubc_pkg::OFS_STATUS) begin
      woke <= 1'b0;
    end
  end

  // wake only from a falling edge seen with wake-up enabled
  wake_edge_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wake_enable && power_down_in && rx_fall) |=> wake_out)
    else $error("missed wake on falling rx");

  no_wake_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wake_out |-> $past(wake_enable) && $past(rx_fall))
    else $error("wake without enable or falling edge");

  // ***************************************************************
  // received word: store, then filter on address bit
  // ***************************************************************
  logic [7:0] word_hold;
  logic       word_pending;
  logic       addr_bit;

  // first stage captures the word and its ninth bit
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      word_hold          <= 8'h00;
      word_pending       <= 1'b0;
      received_ninth_bit <= 1'b0;
    end else if (!rx_pin_own_out) begin
      word_pending       <= 1'b0;
      received_ninth_bit <= uart_master_enable ? received_ninth_bit : 1'b0;
    end else begin
      word_pending <= rx_word_valid_in;
      if (rx_word_valid_in) begin
        word_hold <= rx_word_in;
        if (nine_bit_select) begin
          received_ninth_bit <= rx_bit_eight_in;
        end
      end
    end
  end

  // address bit from the stored word
  assign addr_bit = nine_bit_select ? received_ninth_bit : word_hold[7];

  // second stage delivers or discards
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_deliver_out <= 1'b0;
      rx_data_out    <= 8'h00;
      uart_irq_out   <= 1'b0;
    end else begin
      rx_deliver_out <= 1'b0;
      uart_irq_out   <= 1'b0;
      if (word_pending && rx_pin_own_out && (!address_detect_enable || addr_bit)) begin
        rx_deliver_out <= 1'b1;
        rx_data_out    <= word_hold;
        uart_irq_out   <= rx_int_enable;
      end
    end
  end

  // filter checks against the stored address bit
  addr_irq_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (word_pending && rx_pin_own_out && address_detect_enable && addr_bit && rx_int_enable)
      |=> uart_irq_out && rx_deliver_out)
    else $error("address word raised no request");

  data_drop_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (word_pending && address_detect_enable && !addr_bit) |=> !uart_irq_out && !rx_deliver_out)
    else $error("non-address word not discarded");

  ninth_first_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (rx_word_valid_in && rx_pin_own_out && nine_bit_select) |=>
      (received_ninth_bit == $past(rx_bit_eight_in)))
    else $error("ninth bit not stored ahead of filter");

  // ***************************************************************
  // enable, wake and filter checks
  // ***************************************************************
  // each check looks one cycle past the control bits it depends on
  master_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !uart_master_enable |=> !rx_pin_own_out && !tx_pin_own_out)
    else $error("pin owned with uart disabled");

  rx_held_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !receiver_enable |=> rx_reset_out && !rx_pin_own_out)
    else $error("receiver not held in reset");

  tx_held_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !transmitter_enable |=> tx_reset_out && !tx_pin_own_out)
    else $error("transmitter not held in reset");

  owned_deliver_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    rx_deliver_out |-> $past(rx_pin_own_out))
    else $error("word delivered while receiver off");

  quiet_word_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (word_pending && rx_pin_own_out && address_detect_enable && addr_bit && !rx_int_enable)
      |=> rx_deliver_out && !uart_irq_out)
    else $error("address word request without enable");

  nine_follow_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    nine_bit_select_out == $past(nine_bit_select))
    else $error("word length select not passed on");

  wake_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !wake_enable |=> !wake_out)
    else $error("wake with wake-up disabled");

endmodule : ubc_control

/* File: test/ubc_peer_model.sv */
`timescale 1ns/100ps
// ***************************************************************
// far-side shifter model: receive core and transmitter busy
// ***************************************************************
module ubc_peer_model (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       send_in,
  input  wire logic [8:0] word_in,
  input  wire logic       rx_reset_in,
  input  wire logic       tx_start_in,
  input  wire logic       tx_reset_in,
  output logic            rx_word_valid_out,
  output logic [7:0]      rx_word_out,
  output logic            rx_bit_eight_out,
  output logic            rx_busy_out,
  output logic            tx_busy_out
);
  logic [3:0] bit_cnt;
  logic [8:0] held;

  // an 8-cycle frame, then the word is handed over with a one-cycle valid
  always_ff @(posedge clk_in) begin
    rx_word_valid_out <= 1'b0;
    if (sys_rst_in || rx_reset_in) begin
      rx_busy_out <= 1'b0;
      bit_cnt     <= 4'h0;
    end else if (send_in && !rx_busy_out) begin
      rx_busy_out <= 1'b1;
      bit_cnt     <= 4'h8;
      held        <= word_in;
    end else if (rx_busy_out && bit_cnt == 4'h1) begin
      rx_busy_out       <= 1'b0;
      rx_word_valid_out <= 1'b1;
    end else if (rx_busy_out) begin
      bit_cnt <= bit_cnt - 4'h1;
    end
  end

  // data lines carry the word only beside valid, a toggling pattern otherwise
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      {rx_bit_eight_out, rx_word_out} <= 9'h000;
    end else if (rx_busy_out && bit_cnt == 4'h1) begin
      {rx_bit_eight_out, rx_word_out} <= held;
    end else begin
      {rx_bit_eight_out, rx_word_out} <= ~{rx_bit_eight_out, rx_word_out};
    end
  end

  // transmitter stays busy until the device holds it in reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || tx_reset_in) begin
      tx_busy_out <= 1'b0;
    end else if (tx_start_in) begin
      tx_busy_out <= 1'b1;
    end
  end
endmodule : ubc_peer_model

/* File: test/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic        clk_in, sys_rst_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, rx_word_in, rx_data_out, last_data;
  logic [31:0] pwdata, prdata, rd;
  logic        rx_pin_in, power_down_in, wake_out, rx_word_valid_in, rx_bit_eight_in;
  logic        rx_busy_in, tx_busy_in, rx_deliver_out, uart_irq_out, rx_pin_own_out;
  logic        tx_pin_own_out, rx_reset_out, tx_reset_out, rx_abort_out, tx_abort_out;
  logic        nine_bit_select_out, baud_tick_out, send_in, tx_start_in, slv;
  logic [8:0]  word_in;
  int          err_total, checked, n_del, n_irq, n_wake, p;

  ubc_control uut (.clk_in, .sys_rst_in, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_pin_in, .power_down_in, .wake_out, .rx_word_valid_in,
    .rx_word_in, .rx_bit_eight_in, .rx_busy_in, .tx_busy_in, .rx_deliver_out, .rx_data_out,
    .uart_irq_out, .rx_pin_own_out, .tx_pin_own_out, .rx_reset_out, .tx_reset_out,
    .rx_abort_out, .tx_abort_out, .nine_bit_select_out, .baud_tick_out);

  ubc_peer_model peer (.clk_in, .sys_rst_in, .send_in, .word_in, .rx_reset_in(rx_reset_out),
    .tx_start_in, .tx_reset_in(tx_reset_out), .rx_word_valid_out(rx_word_valid_in),
    .rx_word_out(rx_word_in), .rx_bit_eight_out(rx_bit_eight_in),
    .rx_busy_out(rx_busy_in), .tx_busy_out(tx_busy_in));

  // ***************************************************************
  // clock, pulse counters and helpers
  // ***************************************************************
  initial clk_in = 1'b0;
  always #50 clk_in = ~clk_in;

  // count output pulses where they are settled
  always @(negedge clk_in) begin
    if (rx_deliver_out === 1'b1) begin
      n_del++;
      last_data = rx_data_out;
    end
    if (uart_irq_out === 1'b1) n_irq++;
    if (wake_out === 1'b1) n_wake++;
  end

  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check_val

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // one apb transfer: setup, then access until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    k = 0;
    // request held until the rising edge at which pready is sampled high
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) err_total++;
    rd  = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check_val(rd, exp);
  endtask : rdchk

  task automatic settle;
    repeat (2) @(negedge clk_in);
  endtask : settle

  task automatic send(input logic [8:0] w);
    @(posedge clk_in);
    send_in <= 1'b1;
    word_in <= w;
    @(posedge clk_in);
    send_in <= 1'b0;
    repeat (14) @(posedge clk_in);
  endtask : send

  // one received word under given controls, with expected pulse counts
  task automatic word_case(input logic [7:0] c1, input logic [7:0] c2, input logic [8:0] w,
                           input int d_exp, input int i_exp);
    wr(8'h08, {24'h0, c1});
    wr(8'h00, {24'h0, c2});
    n_del = 0;
    n_irq = 0;
    send(w);
    check_val(32'(n_del), d_exp);
    check_val(32'(n_irq), i_exp);
    if (d_exp == 1) check_val({24'h0, last_data}, {24'h0, w[7:0]});
  endtask : word_case

  task automatic wait_tick;
    p = 0;
    do begin
      @(negedge clk_in);
      p++;
    end while (baud_tick_out !== 1'b1 && p < 20000);
  endtask : wait_tick

  // bit period in clock cycles, measured after the new divisor is reloaded
  task automatic baud_case(input logic spd, input logic [7:0] n, input int exp);
    wr(8'h00, {29'h0, spd, 2'h0});
    wr(8'h04, {24'h0, n});
    repeat (3) wait_tick;
    check_val(32'(p), exp);
  endtask : baud_case

  // ***************************************************************
  // watchdog and main sequence
  // ***************************************************************
  initial begin
    repeat (30000) @(posedge clk_in);
    err_total++;
    wrap_up;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, send_in, tx_start_in, word_in} = '0;
    {power_down_in, rx_pin_in, sys_rst_in} = 3'b011;
    {err_total, checked, n_del, n_irq, n_wake} = '0;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    settle;
    check_val({rx_reset_out, tx_reset_out}, 2'b11);
    for (int i = 0; i < 4; i++) rdchk(8'(4 * i), 32'h0);
    rdchk(8'h10, 32'h0);
    check_val(slv, 1'b1);
    wr(8'h04, 32'hff);
    rdchk(8'h04, 32'hff);
    wr(8'h00, 32'hfc);
    rdchk(8'h00, 32'hfc);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h23);
    settle;
    check_val({rx_pin_own_out, tx_pin_own_out, rx_reset_out, tx_reset_out}, 4'hc);
    rdchk(8'h0c, 32'h6);
    word_case(8'h01, 8'h23, 9'h005, 1, 1);
    word_case(8'h01, 8'h2b, 9'h085, 1, 1);
    word_case(8'h01, 8'h2b, 9'h005, 0, 0);
    word_case(8'h03, 8'h2b, 9'h105, 1, 1);
    rdchk(8'h0c, 32'h7);
    word_case(8'h03, 8'h2b, 9'h0ff, 0, 0);
    word_case(8'h03, 8'h0b, 9'h1aa, 1, 0);
    check_val(nine_bit_select_out, 1'b1);
    // receiver switched off in mid-word
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h23);
    @(posedge clk_in);
    send_in <= 1'b1;
    word_in <= 9'h0aa;
    @(posedge clk_in);
    send_in <= 1'b0;
    n_del = 0;
    wr(8'h00, 32'h21);
    settle;
    check_val({rx_abort_out, rx_reset_out, rx_pin_own_out}, 3'b110);
    repeat (12) @(posedge clk_in);
    check_val(32'(n_del), 0);
    // transmitter switched off in mid-character
    wr(8'h00, 32'h23);
    @(posedge clk_in);
    tx_start_in <= 1'b1;
    @(posedge clk_in);
    tx_start_in <= 1'b0;
    wr(8'h00, 32'h22);
    settle;
    check_val({tx_abort_out, tx_reset_out, tx_pin_own_out}, 3'b110);
    wr(8'h00, 32'h23);
    wr(8'h08, 32'h0);
    settle;
    check_val({rx_pin_own_out, tx_pin_own_out}, 2'b00);
    rdchk(8'h00, 32'h20);
    wr(8'h08, 32'h1);
    baud_case(1'b1, 8'h00, 16);
    baud_case(1'b1, 8'h01, 32);
    baud_case(1'b0, 8'h00, 64);
    baud_case(1'b0, 8'h02, 192);
    baud_case(1'b1, 8'hff, 4096);
    // wake-up on a falling pin edge in power-down
    wr(8'h00, 32'h10);
    power_down_in <= 1'b1;
    n_wake = 0;
    @(posedge clk_in);
    rx_pin_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    check_val(32'(n_wake), 1);
    rdchk(8'h0c, 32'h8);
    rx_pin_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    wr(8'h00, 32'h0);
    rx_pin_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    check_val(32'(n_wake), 1);
    wr(8'h0c, 32'h0);
    rdchk(8'h0c, 32'h0);
    wrap_up;
  end
endmodule : testbench
